// ---- rtl/mace_consts.svh ----
`ifndef MACE_CONSTS_SVH
`define MACE_CONSTS_SVH

// slice geometry
`define MACE_ELEMS      4
`define MACE_OP_W       36
`define MACE_ACC_W      72
`define MACE_EXT_W      74

// selectable operand widths
`define MACE_W_NARROW   9
`define MACE_W_MID      18
`define MACE_W_WIDE     36

`endif

// ---- rtl/mace_pkg.sv ----
`include "mace_consts.svh"

package mace_pkg;

   // shared operand width of the whole slice; the last code is illegal
   typedef enum logic [1:0] {
      MACE_W9,
      MACE_W18,
      MACE_W36,
      MACE_WBAD
   } mace_width_e;

   // static per-element configuration
   typedef struct packed {
      logic sgn;        // both operands signed
      logic in_reg;     // operand input register in use
      logic pipe_reg;   // product pipeline register in use
      logic chain;      // add to neighbour's result instead of own sum
   } mace_cfg_s;

   // one operation offered by user logic
   typedef struct packed {
      logic                    valid;
      logic                    load;
      logic [`MACE_OP_W-1:0]   a;
      logic [`MACE_OP_W-1:0]   b;
      logic [`MACE_ACC_W-1:0]  init;
   } mace_op_s;

   // operation after the multiplier
   typedef struct packed {
      logic                    valid;
      logic                    load;
      logic [`MACE_EXT_W-1:0]  prod;
      logic [`MACE_ACC_W-1:0]  init;
   } mace_stage_s;

endpackage

// ---- rtl/mace_slice.sv ----
// Operation
// - four elements, each working at 9, 18 or 36 bit operand width.
// - within an element both operands are signed or both unsigned.
// - one width for the whole slice; an illegal width code is refused.
// - each active cycle adds A times B to the prior accumulator value.
// - input and pipeline registers optional; output register always clocked.
// - the output register holds the running sum fed back to the adder.
// - user logic may load a starting value into the accumulator at run time.
// - overflow flag comes from a register, aligned with the accumulator output.
// - elements chain, each able to add onto its neighbour's result.
`timescale 1ns/10ps
`default_nettype none
`include "mace_consts.svh"

module mace_slice (
   input  wire  logic                                          clock_i,
   input  wire  logic                                          sys_rst_i,
   input  wire  logic                                          ce_i,
   input  wire  mace_pkg::mace_width_e                         width_i,
   input  wire  mace_pkg::mace_cfg_s [`MACE_ELEMS-1:0]         cfg_i,
   input  wire  mace_pkg::mace_op_s  [`MACE_ELEMS-1:0]         op_i,
   input  wire  logic [`MACE_ACC_W-1:0]                        cascade_i,
   output var   logic [`MACE_ELEMS-1:0][`MACE_ACC_W-1:0]       acc_o,
   output var   logic [`MACE_ELEMS-1:0]                        ovf_o,
   output var   logic [`MACE_ELEMS-1:0]                        valid_o,
   output var   logic                                          cfg_err_o
);
   import mace_pkg::*;

   // operand width in bits for a width code
   function automatic int unsigned op_width(input mace_width_e w);
      int unsigned r;
      r = `MACE_W_WIDE;
      unique case (w)
         MACE_W9:   r = `MACE_W_NARROW;
         MACE_W18:  r = `MACE_W_MID;
         MACE_W36:  r = `MACE_W_WIDE;
         MACE_WBAD: r = `MACE_W_WIDE;
      endcase
      return r;
   endfunction

   // cut an operand to its width and extend it by the element's signedness
   function automatic logic [`MACE_OP_W:0] ext_op(input logic [`MACE_OP_W-1:0] x,
                                                  input int unsigned w, input logic sgn);
      logic [`MACE_OP_W:0] r;
      r = '0;
      for (int i = 0; i <= `MACE_OP_W; i++) begin
         if (i < int'(w)) begin
            r[i] = x[i];
         end else begin
            r[i] = sgn & x[w-1];
         end
      end
      return r;
   endfunction

   // wrap a wide value into aw bits, extended by signedness
   function automatic logic [`MACE_EXT_W-1:0] fold(input logic [`MACE_EXT_W-1:0] v,
                                                   input int unsigned aw, input logic sgn);
      logic [`MACE_EXT_W-1:0] r;
      r = '0;
      for (int i = 0; i < `MACE_EXT_W; i++) begin
         if (i < int'(aw)) begin
            r[i] = v[i];
         end else begin
            r[i] = sgn & v[aw-1];
         end
      end
      return r;
   endfunction

   // accumulator-width value widened for the adder
   function automatic logic [`MACE_EXT_W-1:0] widen(input logic [`MACE_ACC_W-1:0] v,
                                                    input logic sgn);
      return {{(`MACE_EXT_W-`MACE_ACC_W){sgn & v[`MACE_ACC_W-1]}}, v};
   endfunction

   mace_op_s    [`MACE_ELEMS-1:0]                  in_q;
   mace_op_s    [`MACE_ELEMS-1:0]                  next_in_q;
   mace_stage_s [`MACE_ELEMS-1:0]                  pipe_q;
   mace_stage_s [`MACE_ELEMS-1:0]                  next_pipe_q;
   mace_op_s    [`MACE_ELEMS-1:0]                  in_sel;
   mace_stage_s [`MACE_ELEMS-1:0]                  mul_c;
   mace_stage_s [`MACE_ELEMS-1:0]                  acc_in;
   logic        [`MACE_ELEMS-1:0][`MACE_ACC_W-1:0] next_acc;
   logic        [`MACE_ELEMS-1:0]                  next_ovf;
   logic        [`MACE_ELEMS-1:0]                  next_valid;
   logic                                           next_cfg_err;
   logic                                           width_bad;
   int unsigned                                    ow;

   assign width_bad = (width_i == MACE_WBAD);
   assign ow        = op_width(width_i);

   // input and multiplier stages; the unused register still loads but is bypassed
   always_comb begin
      logic [`MACE_OP_W:0] ea;
      logic [`MACE_OP_W:0] eb;
      ea = '0;
      eb = '0;
      for (int e = 0; e < `MACE_ELEMS; e++) begin
         next_in_q[e]   = ce_i ? op_i[e] : in_q[e];
         in_sel[e]      = cfg_i[e].in_reg ? in_q[e] : op_i[e];
         ea             = ext_op(in_sel[e].a, ow, cfg_i[e].sgn);
         eb             = ext_op(in_sel[e].b, ow, cfg_i[e].sgn);
         mul_c[e].valid = in_sel[e].valid;
         mul_c[e].load  = in_sel[e].load;
         mul_c[e].init  = in_sel[e].init;
         mul_c[e].prod  = $signed(ea) * $signed(eb);
         next_pipe_q[e] = ce_i ? mul_c[e] : pipe_q[e];
         acc_in[e]      = cfg_i[e].pipe_reg ? pipe_q[e] : mul_c[e];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         in_q   <= '0;
         pipe_q <= '0;
      end else begin
         in_q   <= next_in_q;
         pipe_q <= next_pipe_q;
      end
   end

   // accumulator stage: the output register is the running sum
   always_comb begin
      logic [`MACE_EXT_W-1:0] addend;
      logic [`MACE_EXT_W-1:0] sum;
      logic [`MACE_EXT_W-1:0] wrapped;
      logic [`MACE_EXT_W-1:0] init_w;
      addend       = '0;
      sum          = '0;
      wrapped      = '0;
      init_w       = '0;
      next_cfg_err = ce_i ? width_bad : cfg_err_o;
      for (int e = 0; e < `MACE_ELEMS; e++) begin
         next_acc[e]   = acc_o[e];
         next_ovf[e]   = ovf_o[e];
         next_valid[e] = ce_i ? 1'b0 : valid_o[e];
         // neighbour result feeds the chain; element 0 takes the slice input
         if (cfg_i[e].chain) begin
            addend = widen((e == 0) ? cascade_i : acc_o[(e == 0) ? 0 : e-1], cfg_i[e].sgn);
         end else begin
            addend = widen(acc_o[e], cfg_i[e].sgn);
         end
         sum     = addend + acc_in[e].prod;
         wrapped = fold(sum, 2*ow, cfg_i[e].sgn);
         // an illegal width stalls every element rather than produce garbage
         if (ce_i && !width_bad && acc_in[e].valid) begin
            next_valid[e] = 1'b1;
            if (acc_in[e].load) begin
               // start value is wrapped like a sum, so a wide init cannot leave the range
               init_w      = fold(widen(acc_in[e].init, cfg_i[e].sgn), 2*ow, cfg_i[e].sgn);
               next_acc[e] = init_w[`MACE_ACC_W-1:0];
               next_ovf[e] = 1'b0;
            end else begin
               next_acc[e] = wrapped[`MACE_ACC_W-1:0];
               next_ovf[e] = ovf_o[e] | (wrapped != sum);
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         acc_o     <= '0;
         ovf_o     <= '0;
         valid_o   <= '0;
         cfg_err_o <= 1'b0;
      end else begin
         acc_o     <= next_acc;
         ovf_o     <= next_ovf;
         valid_o   <= next_valid;
         cfg_err_o <= next_cfg_err;
      end
   end

   // checks watch element 0 and 1, the reject and freeze checks all four; the elements are identical copies
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_direct_latency;
      (ce_i && !width_bad && op_i[0].valid && !cfg_i[0].in_reg && !cfg_i[0].pipe_reg) |=> valid_o[0];
   endproperty
   a_direct_latency: assert property (p_direct_latency) else $error("direct path did not answer in one cycle");

   property p_full_latency;
      (ce_i && !width_bad && op_i[0].valid && cfg_i[0].in_reg && cfg_i[0].pipe_reg)
         ##1 (ce_i && !width_bad && cfg_i[0].in_reg && cfg_i[0].pipe_reg)
         ##1 (ce_i && !width_bad && cfg_i[0].pipe_reg) |=> valid_o[0];
   endproperty
   a_full_latency: assert property (p_full_latency) else $error("registered path did not answer in three cycles");

   property p_load_clears;
      (ce_i && !width_bad && acc_in[0].valid && acc_in[0].load) |=> (valid_o[0] && !ovf_o[0]);
   endproperty
   a_load_clears: assert property (p_load_clears) else $error("load did not clear overflow");

   property p_ovf_aligned;
      $rose(ovf_o[0]) |-> valid_o[0];
   endproperty
   a_ovf_aligned: assert property (p_ovf_aligned) else $error("overflow rose without a result");

   property p_ovf_sticky;
      (ovf_o[0] && !(ce_i && acc_in[0].valid && acc_in[0].load)) |=> ovf_o[0];
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped without a load");

   property p_hold_sum;
      !(ce_i && !width_bad && acc_in[0].valid) |=> $stable(acc_o[0]) && !valid_o[0] || !$past(ce_i);
   endproperty
   a_hold_sum: assert property (p_hold_sum) else $error("accumulator moved without an operation");

   property p_zero_product;
      (ce_i && !width_bad && acc_in[0].valid && !acc_in[0].load && !cfg_i[0].chain
         && acc_in[0].prod == '0 && width_i == MACE_W36) |=> $stable(acc_o[0]);
   endproperty
   a_zero_product: assert property (p_zero_product) else $error("zero product changed the sum");

   property p_chain;
      (ce_i && width_i == MACE_W36 && acc_in[1].valid && !acc_in[1].load && cfg_i[1].chain
         && acc_in[1].prod == '0 && cfg_i[1].sgn == cfg_i[0].sgn) |=> acc_o[1] == $past(acc_o[0]);
   endproperty
   a_chain: assert property (p_chain) else $error("chained element lost its neighbour's result");

   property p_unsigned_range;
      (ce_i && acc_in[0].valid && width_i == MACE_W9 && !cfg_i[0].sgn) |=> acc_o[0][71:18] == '0;
   endproperty
   a_unsigned_range: assert property (p_unsigned_range) else $error("narrow unsigned sum out of range");

   property p_signed_range;
      (ce_i && acc_in[0].valid && width_i == MACE_W9 && cfg_i[0].sgn)
         |=> (acc_o[0][71:17] == '0 || acc_o[0][71:17] == '1);
   endproperty
   a_signed_range: assert property (p_signed_range) else $error("narrow signed sum not extended");

   property p_reject;
      (ce_i && width_bad) |=> (cfg_err_o && valid_o == '0);
   endproperty
   a_reject: assert property (p_reject) else $error("illegal width was not refused");

   property p_freeze;
      !ce_i |=> ($stable(acc_o) && $stable(ovf_o) && $stable(valid_o));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   c_load:  cover property (ce_i && acc_in[0].valid && acc_in[0].load);
   c_ovf:   cover property ($rose(ovf_o[0]));
   c_chain: cover property (valid_o[1] && cfg_i[1].chain);
   c_full:  cover property (valid_o[0] && cfg_i[0].in_reg && cfg_i[0].pipe_reg);

endmodule
`default_nettype wire

// ---- tb/mace_user_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// fabric-side user logic: offers one operation to one element at a time
module mace_user_model (
   input  wire logic                   clock_i,
   output var  mace_pkg::mace_op_s [3:0] op_o
);
   import mace_pkg::*;

   initial op_o = '0;

   // valid is a one-cycle pulse; the released fields are inverted, so stale data is never mistaken for the op
   task automatic send(input int e, input logic ld, input logic [35:0] a, input logic [35:0] b,
                       input logic [71:0] init);
      @(posedge clock_i);
      op_o[e] <= {1'b1, ld, a, b, init};
      @(posedge clock_i);
      op_o[e] <= {1'b0, ~ld, ~a, ~b, ~init};
   endtask
endmodule

`default_nettype wire

// ---- tb/multiply_accumulate_element_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module multiply_accumulate_element_tb_top;
   import mace_pkg::*;

   logic              clock_i      = 1'b0;
   logic              sys_rst_i    = 1'b1;
   mace_width_e       width        = MACE_W18;
   mace_cfg_s [3:0]   cfg          = {4'b1000, 4'b0110, 4'b0001, 4'b0000};
   mace_op_s [3:0]    op;
   logic [3:0][71:0]  acc;
   logic [3:0]        ovf;
   logic [3:0]        vld;
   logic              cfg_err;
   logic              ce           = 1'b1;
   logic [71:0]       cascade      = 72'h0;
   int                n_mismatch   = 0;
   int                total_checks = 0;

   always #5 clock_i = ~clock_i;

   // enable and cascade are driven only by the freeze and chain scenarios
   mace_slice uut (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce),
      .width_i   (width),
      .cfg_i     (cfg),
      .op_i      (op),
      .cascade_i (cascade),
      .acc_o     (acc),
      .ovf_o     (ovf),
      .valid_o   (vld),
      .cfg_err_o (cfg_err)
   );

   mace_user_model um (
      .clock_i (clock_i),
      .op_o    (op)
   );

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // valid must stay low until exactly lat edges after the op was taken
   task automatic run(input int e, input logic ld, input logic [35:0] a, input logic [35:0] b,
                      input logic [71:0] init, input int lat, input logic [71:0] exp);
      um.send(e, ld, a, b, init);
      #1;
      for (int i = 1; i < lat; i++) begin
         chk({71'h0, vld[e]}, 72'h0);
         @(posedge clock_i);
         #1;
      end
      chk({71'h0, vld[e]}, 72'h1);
      chk(acc[e], exp);
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // the whole sequence needs well under a thousand cycles
   initial begin
      #100000;
      n_mismatch++;
      final_report;
   end

   // reset release: every flag and element 0's sum must come up cleared
   task automatic t_reset;
      repeat (6) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      chk({63'h0, ovf, vld, cfg_err}, 72'h0);
      chk(acc[0], 72'h0);
   endtask

   // load a start value, then accumulate on top of it
   task automatic t_load_accum;
      run(0, 1'b1, 36'h0, 36'h0, 72'h5, 1, 72'h5);
      run(0, 1'b0, 36'h2, 36'h3, 72'h0, 1, 72'hb);
   endtask

   // element 1 adds onto element 0's sum, then element 0 adds onto the slice input
   task automatic t_chain;
      run(1, 1'b0, 36'h1, 36'h1, 72'h0, 1, 72'hc);
      @(posedge clock_i);
      cascade      <= 72'h100;
      cfg[0].chain <= 1'b1;
      run(0, 1'b0, 36'h1, 36'h1, 72'h0, 1, 72'h101);
      @(posedge clock_i);
      cfg[0].chain <= 1'b0;
   endtask

   // element 2 has both optional registers: three edges
   task automatic t_pipeline;
      run(2, 1'b1, 36'h0, 36'h0, 72'h7, 3, 72'h7);
      run(2, 1'b0, 36'h4, 36'h5, 72'h0, 3, 72'h1b);
   endtask

   // enable low parks an op in the input register; disabled edges must not count
   task automatic t_freeze;
      um.send(2, 1'b0, 36'h1, 36'h1, 72'h0);
      ce <= 1'b0;
      repeat (3) @(posedge clock_i);
      #1;
      chk({71'h0, vld[2]}, 72'h0);
      chk(acc[2], 72'h1b);
      @(posedge clock_i);
      ce <= 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      chk({71'h0, vld[2]}, 72'h1);
      chk(acc[2], 72'h1c);
   endtask

   // signed narrow product sign-extends into the full accumulator
   task automatic t_signed_narrow;
      @(posedge clock_i);
      width <= MACE_W9;
      run(3, 1'b1, 36'h0, 36'h0, 72'h0, 1, 72'h0);
      run(3, 1'b0, 36'h1fe, 36'h3, 72'h0, 1, 72'hffffffffffffffff_fa);
   endtask

   // unsigned 18-bit sum wraps and sets the sticky flag; a load clears it
   task automatic t_overflow;
      run(0, 1'b1, 36'h0, 36'h0, 72'h3ffff, 1, 72'h3ffff);
      run(0, 1'b0, 36'h1, 36'h1, 72'h0, 1, 72'h0);
      chk({71'h0, ovf[0]}, 72'h1);
      run(0, 1'b1, 36'h0, 36'h0, 72'h1, 1, 72'h1);
      chk({71'h0, ovf[0]}, 72'h0);
   endtask

   // illegal width code: op lost, error flag raised, then cleared
   task automatic t_reject;
      @(posedge clock_i);
      width <= MACE_WBAD;
      um.send(0, 1'b0, 36'h1, 36'h1, 72'h0);
      #1;
      chk({71'h0, vld[0]}, 72'h0);
      chk({71'h0, cfg_err}, 72'h1);
      chk(acc[0], 72'h1);
      @(posedge clock_i);
      width <= MACE_W18;
      repeat (2) @(posedge clock_i);
      #1;
      chk({71'h0, cfg_err}, 72'h0);
   endtask

   // widest operands: signed product, then zero products leave element 0's sum as it is and copy it into chained element 1
   task automatic t_wide;
      @(posedge clock_i);
      width <= MACE_W36;
      run(3, 1'b1, 36'h0, 36'h0, 72'h0, 1, 72'h0);
      run(3, 1'b0, 36'hfffffffff, 36'h2, 72'h0, 1, 72'hffffffffffffffff_fe);
      run(0, 1'b0, 36'h0, 36'h5, 72'h0, 1, 72'h1);
      run(1, 1'b0, 36'h0, 36'h0, 72'h0, 1, 72'h1);
   endtask

   initial begin
      t_reset;
      t_load_accum;
      t_chain;
      t_pipeline;
      t_freeze;
      t_signed_narrow;
      t_overflow;
      t_reject;
      t_wide;
      final_report;
   end
endmodule

`default_nettype wire
